// [rtl/acspi_device.sv]
`timescale 1ns/1ps
`include "acspi_map.svh"
module acspi_device #(
    parameter int NVM_DEPTH = 64,
    parameter logic [15:0] TEMP_PERIOD = `ACSPI_TEMP_PERIOD
) (
    input wire logic mclk,
    input wire logic rst_n,
    acspi_if.device link,
    input wire logic [29:0] accSample,
    input wire logic [7:0] tempSample,
    output logic range10g,
    output logic [7:0] nvmWrData,
    output logic [6:0] nvmWrAddr,
    output logic nvmWrStb
);
    logic sckPrev_ff;
    logic [3:0] bitCnt_ff;
    logic [15:0] shIn_ff;
    logic [7:0] shOut_ff;
    logic misoOe_ff;
    logic misoBit_ff;
    logic [7:0] nvm_ff [NVM_DEPTH];
    logic [7:0] nvmRead_ff;
    logic [2:0] accLsbHold_ff [3];
    logic nvmPend_ff;
    logic frameEnd;
    logic [7:0] temp_ff;
    logic [15:0] tempCnt_ff;
    logic range_ff;
    logic sckRise;
    logic sckFall;
    logic [15:0] nxt_word;
    acspi_pkg::acspi_addr_t rdAddr;
    acspi_pkg::acspi_byte_t rdByte;

    assign sckRise = !link.csN && link.sck && !sckPrev_ff;
    assign sckFall = !link.csN && !link.sck && sckPrev_ff;
    assign nxt_word = {shIn_ff[14:0], link.mosi};
    assign rdAddr = shIn_ff[6:0];
    assign frameEnd = sckRise && bitCnt_ff == `ACSPI_LAST_BIT;

    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            sckPrev_ff <= 1'b1;
        end else begin
            sckPrev_ff <= link.sck;
        end
    end

    // Bit counter restarts on each select so a short frame cannot skew the next
    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            bitCnt_ff <= '0;
            shIn_ff <= '0;
        end else if (link.csN) begin
            bitCnt_ff <= '0;
        end else if (sckRise) begin
            shIn_ff <= nxt_word;
            bitCnt_ff <= bitCnt_ff + 4'h1;
        end
    end

    // Read data selection, from address just received
    always_comb begin
        rdByte = 8'h00;
        case (rdAddr)
            `ACSPI_ADDR_ACC_MSB_X: rdByte = {1'b0, accSample[9:3]};
            `ACSPI_ADDR_ACC_LSB_X: rdByte = {5'h00, accLsbHold_ff[0]};
            `ACSPI_ADDR_ACC_MSB_Y: rdByte = {1'b0, accSample[19:13]};
            `ACSPI_ADDR_ACC_LSB_Y: rdByte = {5'h00, accLsbHold_ff[1]};
            `ACSPI_ADDR_ACC_MSB_Z: rdByte = {1'b0, accSample[29:23]};
            `ACSPI_ADDR_ACC_LSB_Z: rdByte = {5'h00, accLsbHold_ff[2]};
            `ACSPI_ADDR_TEMP: rdByte = temp_ff;
            `ACSPI_ADDR_RANGE: rdByte = {7'h00, range_ff};
            default: rdByte = 8'h00;
        endcase
        // A memory fetch started by the previous frame wins over this frame's
        // address, so the host may follow up with any read command
        if (nvmPend_ff) begin
            rdByte = nvmRead_ff;
        end
    end

    // Output shifter loads after the last address bit (frame bit 8), drives on falling edges
    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            shOut_ff <= '0;
            misoOe_ff <= 1'b0;
            misoBit_ff <= 1'b0;
        end else if (link.csN) begin
            misoOe_ff <= 1'b0;
        end else if (sckFall) begin
            if (bitCnt_ff == `ACSPI_DATA_FIRST && shIn_ff[7]) begin
                misoOe_ff <= 1'b1;
                misoBit_ff <= rdByte[7];
                shOut_ff <= {rdByte[6:0], 1'b0};
            end else if (bitCnt_ff == 4'h0) begin
                misoOe_ff <= 1'b0;
            end else if (misoOe_ff) begin
                misoBit_ff <= shOut_ff[7];
                shOut_ff <= {shOut_ff[6:0], 1'b0};
            end
        end
    end
    assign link.misoOut = misoBit_ff;
    assign link.misoOeN = !misoOe_ff;

    // Completed frames: writes, range select, memory prefetch
    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            range_ff <= 1'b0;
            nvmRead_ff <= '0;
            nvmPend_ff <= 1'b0;
            nvmWrStb <= 1'b0;
            nvmWrAddr <= '0;
            nvmWrData <= '0;
        end else begin
            nvmWrStb <= 1'b0;
            if (frameEnd) begin
                if (!nxt_word[15]) begin
                    nvmWrStb <= 1'b1;
                    nvmPend_ff <= 1'b0;
                    nvmWrAddr <= nxt_word[14:8];
                    nvmWrData <= nxt_word[7:0];
                    if (nxt_word[14:8] == `ACSPI_ADDR_RANGE) begin
                        range_ff <= nxt_word[`ACSPI_RANGE_BIT];
                    end
                end else begin
                    // Slow array: byte fetched now, shifted out next frame
                    nvmRead_ff <= nvm_ff[nxt_word[8 +: $clog2(NVM_DEPTH)]];
                    nvmPend_ff <= nxt_word[14:8] >= `ACSPI_ADDR_NVM_LO;
                end
            end
        end
    end
    assign range10g = range_ff;

    // One freeze register per axis; the end of its MSB read snapshots the LSBs, so a later
    // LSB read matches the MSB byte only if accSample held still since that byte loaded at bit 8
    for (genvar ax = 0; ax < 3; ax++) begin : g_lsbHold
        logic msbRead;
        assign msbRead = frameEnd && nxt_word[15] && nxt_word[14:8] == `ACSPI_ADDR_ACC_MSB_X + 7'(2 * ax);
        always_ff @(posedge mclk or negedge rst_n) begin
            if (!rst_n) begin
                accLsbHold_ff[ax] <= '0;
            end else if (msbRead) begin
                accLsbHold_ff[ax] <= accSample[10 * ax +: 3];
            end
        end
    end

    // Array has no reset: contents are only defined once written
    always_ff @(posedge mclk) begin
        if (frameEnd && !nxt_word[15] && nxt_word[14]) begin
            nvm_ff[nxt_word[8 +: $clog2(NVM_DEPTH)]] <= nxt_word[7:0];
        end
    end

    // Temperature refresh timer
    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            tempCnt_ff <= '0;
            temp_ff <= '0;
        end else if (tempCnt_ff == TEMP_PERIOD - 16'h0001) begin
            tempCnt_ff <= '0;
            temp_ff <= tempSample;
        end else begin
            tempCnt_ff <= tempCnt_ff + 16'h0001;
        end
    end
endmodule // acspi_device

// [rtl/acspi_map.svh]
`ifndef ACSPI_MAP_SVH
`define ACSPI_MAP_SVH
`define ACSPI_FRAME_BITS 16
`define ACSPI_CNT_W 4
`define ACSPI_LAST_BIT 4'hF
`define ACSPI_DATA_FIRST 4'h8
`define ACSPI_SCK_DIV 8'h04
`define ACSPI_TEMP_PERIOD 16'h2710
`define ACSPI_ADDR_ACC_MSB_X 7'h02
`define ACSPI_ADDR_ACC_LSB_X 7'h03
`define ACSPI_ADDR_ACC_MSB_Y 7'h04
`define ACSPI_ADDR_ACC_LSB_Y 7'h05
`define ACSPI_ADDR_ACC_MSB_Z 7'h06
`define ACSPI_ADDR_ACC_LSB_Z 7'h07
`define ACSPI_ADDR_TEMP 7'h08
`define ACSPI_ADDR_RANGE 7'h14
`define ACSPI_ADDR_NVM_LO 7'h40
`define ACSPI_RANGE_BIT 0
`endif

// [rtl/acspi_pkg.sv]
package acspi_pkg;
    typedef enum logic [1:0] {
        ACSPI_IDLE = 2'b00,
        ACSPI_SHIFT = 2'b01,
        ACSPI_GAP = 2'b10,
        ACSPI_DONE = 2'b11
    } acspi_state_e;
    typedef logic [6:0] acspi_addr_t;
    typedef logic [7:0] acspi_byte_t;
endpackage

// [rtl/acspi_if.sv]
`timescale 1ns/1ps
interface acspi_if;
    logic sck;
    logic csN;
    logic mosi;
    logic misoOut;
    logic misoOeN;
    modport device (
        input sck,
        input csN,
        input mosi,
        output misoOut,
        output misoOeN
    );
    modport host (
        output sck,
        output csN,
        output mosi,
        input misoOut,
        input misoOeN
    );
endinterface // acspi_if

// [rtl/acspi_host.sv]
`timescale 1ns/1ps
`include "acspi_map.svh"
module acspi_host (
    input wire logic mclk,
    input wire logic rst_n,
    acspi_if.host link,
    input wire logic reqValid,
    output logic reqReady,
    input wire logic reqRead,
    input wire logic [6:0] reqAddr,
    input wire logic [7:0] reqData,
    output logic rspValid,
    output logic [7:0] rspData
);
    logic [7:0] divCnt_ff;
    logic tick;
    acspi_pkg::acspi_state_e state_ff;
    logic [15:0] shOut_ff;
    logic [7:0] shIn_ff;
    logic [4:0] edges_ff;
    logic sck_ff;
    logic cs_ff;
    logic isRead_ff;

    assign tick = divCnt_ff == `ACSPI_SCK_DIV - 8'h01;
    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            divCnt_ff <= '0;
        end else begin
            divCnt_ff <= tick ? 8'h00 : divCnt_ff + 8'h01;
        end
    end

    assign reqReady = state_ff == acspi_pkg::ACSPI_IDLE;

    // Mode 3: clock idles high, host drives on falling, samples on rising
    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            state_ff <= acspi_pkg::ACSPI_IDLE;
            shOut_ff <= '0;
            shIn_ff <= '0;
            edges_ff <= '0;
            sck_ff <= 1'b1;
            cs_ff <= 1'b1;
            isRead_ff <= 1'b0;
            rspValid <= 1'b0;
            rspData <= '0;
        end else begin
            rspValid <= 1'b0;
            case (state_ff)
                acspi_pkg::ACSPI_IDLE: begin
                    if (reqValid) begin
                        shOut_ff <= {reqRead, reqAddr, reqRead ? 8'h00 : reqData};
                        isRead_ff <= reqRead;
                        cs_ff <= 1'b0;
                        edges_ff <= '0;
                        state_ff <= acspi_pkg::ACSPI_GAP;
                    end
                end
                acspi_pkg::ACSPI_GAP: begin
                    if (tick) begin
                        state_ff <= acspi_pkg::ACSPI_SHIFT;
                    end
                end
                acspi_pkg::ACSPI_SHIFT: begin
                    if (tick) begin
                        sck_ff <= !sck_ff;
                        edges_ff <= edges_ff + 5'h01;
                        if (sck_ff && edges_ff != 5'h00) begin
                            shOut_ff <= {shOut_ff[14:0], 1'b0};
                        end
                        if (!sck_ff) begin
                            shIn_ff <= {shIn_ff[6:0], link.misoOut};
                        end
                        if (edges_ff == 5'h1F) begin
                            state_ff <= acspi_pkg::ACSPI_DONE;
                        end
                    end
                end
                acspi_pkg::ACSPI_DONE: begin
                    if (tick) begin
                        cs_ff <= 1'b1;
                        rspValid <= isRead_ff;
                        rspData <= shIn_ff;
                        state_ff <= acspi_pkg::ACSPI_IDLE;
                    end
                end
                default: state_ff <= acspi_pkg::ACSPI_IDLE;
            endcase
        end
    end
    assign link.sck = sck_ff;
    assign link.csN = cs_ff;
    assign link.mosi = shOut_ff[15];
endmodule // acspi_host

// [bench/acspi_sva.sv]
`timescale 1ns/1ps
module acspi_sva (
    input wire logic mclk,
    input wire logic rst_n,
    input wire logic sck,
    input wire logic csN,
    input wire logic mosi,
    input wire logic misoOut,
    input wire logic misoOeN
);
    default clocking cb @(posedge mclk); endclocking
    default disable iff (!rst_n);
    logic [4:0] edgeCnt_ff;
    logic rw_ff;
    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) edgeCnt_ff <= 5'h00;
        else if (csN) edgeCnt_ff <= 5'h00;
        else if ($rose(sck)) edgeCnt_ff <= edgeCnt_ff + 5'h01;
    end
    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) rw_ff <= 1'b0;
        else if (!csN && $rose(sck) && edgeCnt_ff == 5'h00) rw_ff <= mosi;
    end
    sequence s_lowHalf;
        !sck [*4];
    endsequence
    property p_sckIdle; csN |-> sck; endproperty
    property p_lowHalf; $fell(sck) |-> s_lowHalf ##1 sck; endproperty
    property p_frameLen; $rose(csN) |-> edgeCnt_ff == 5'h10; endproperty
    property p_csStart; $fell(csN) |-> ##[1:8] $fell(sck); endproperty
    property p_hizIdle; csN [*2] |-> misoOeN; endproperty
    property p_addrHiz; !csN && edgeCnt_ff < 5'h08 |-> misoOeN; endproperty
    property p_writeHiz; !csN && edgeCnt_ff != 5'h00 && !rw_ff |-> misoOeN; endproperty
    property p_misoFall; !misoOeN && $changed(misoOut) |-> !sck; endproperty
    property p_mosiHold; !csN && !$past(csN) && sck && $past(sck) |-> $stable(mosi); endproperty
    a_sckIdle: assert property (p_sckIdle) else $error("clock not idle high");
    a_lowHalf: assert property (p_lowHalf) else $error("clock low phase length");
    a_frameLen: assert property (p_frameLen) else $error("frame not 16 edges");
    a_csStart: assert property (p_csStart) else $error("no clock after select");
    a_hizIdle: assert property (p_hizIdle) else $error("output driven while idle");
    a_addrHiz: assert property (p_addrHiz) else $error("output driven in address");
    a_writeHiz: assert property (p_writeHiz) else $error("output driven in write");
    a_misoFall: assert property (p_misoFall) else $error("output moved with clock high");
    a_mosiHold: assert property (p_mosiHold) else $error("input moved with clock high");
endmodule // acspi_sva

// [bench/accel_sensor_spi_slave_tb.sv]
`timescale 1ns/1ps
module accel_sensor_spi_slave_tb;
    logic mclk, rst_n, reqValid, reqReady, reqRead, rspValid, range10g, nvmWrStb;
    logic [6:0] reqAddr, nvmWrAddr;
    logic [7:0] reqData, rspData, tempSample, nvmWrData;
    logic [29:0] accSample;
    logic [15:0] mosiSh, misoSh;
    logic [14:0] stbSeen;
    logic [9:0] ax [3] = '{10'h2B5, 10'h3FF, 10'h001};
    logic [7:0] tv [2] = '{8'hA7, 8'h3C};
    int n_fail, checked, cyc;
    acspi_if lnk();
    acspi_device #(.TEMP_PERIOD(16'h0014)) u_acspi_device (.mclk(mclk), .rst_n(rst_n), .link(lnk.device),
        .accSample(accSample), .tempSample(tempSample), .range10g(range10g), .nvmWrData(nvmWrData),
        .nvmWrAddr(nvmWrAddr), .nvmWrStb(nvmWrStb));
    acspi_host u_acspi_host (.mclk(mclk), .rst_n(rst_n), .link(lnk.host), .reqValid(reqValid),
        .reqReady(reqReady), .reqRead(reqRead), .reqAddr(reqAddr), .reqData(reqData),
        .rspValid(rspValid), .rspData(rspData));
    acspi_sva u_acspi_sva (.mclk(mclk), .rst_n(rst_n), .sck(lnk.sck), .csN(lnk.csN), .mosi(lnk.mosi),
        .misoOut(lnk.misoOut), .misoOeN(lnk.misoOeN));
    // Clock stands high between frames, so only frame bits shift in
    always @(posedge lnk.sck) begin
        mosiSh <= {mosiSh[14:0], lnk.mosi};
        misoSh <= {misoSh[14:0], lnk.misoOeN ? 1'b0 : lnk.misoOut};
    end
    always @(posedge mclk) begin
        if (nvmWrStb === 1'b1) stbSeen <= {nvmWrAddr, nvmWrData};
        cyc <= cyc + 1;
        if (cyc == 20000) begin
            n_fail = n_fail + 1;
            report_and_stop();
        end
    end
    initial begin
        mclk = 1'b0;
        forever #50 mclk = ~mclk;
    end
    task automatic chk(input logic [15:0] g, input logic [15:0] e);
        checked = checked + 1;
        if (g !== e) begin
            n_fail = n_fail + 1;
            $display("BAD t=%0t got=%h exp=%h", $time, g, e);
        end
    endtask
    // For reads d is the expected byte, checked only when ck is set
    task automatic xfer(input logic rd, input logic [6:0] a, input logic [7:0] d, input logic ck);
        int i;
        @(posedge mclk);
        reqValid <= 1'b1;
        reqRead <= rd;
        reqAddr <= a;
        reqData <= d;
        @(negedge mclk);
        while (reqReady !== 1'b1) @(negedge mclk);
        @(posedge mclk);
        reqValid <= 1'b0;
        for (i = 0; i < 400 && rspValid !== 1'b1 && !(!rd && i > 150 && lnk.csN); i++) @(negedge mclk);
        chk({mosiSh[15:8], rd ? 8'h00 : mosiSh[7:0]}, {rd, a, rd ? 8'h00 : d});
        if (!rd) chk({1'b0, stbSeen}, {1'b0, a, d});
        if (rd && ck) chk({misoSh[7:0], rspData}, {d, d});
    endtask
    task automatic report_and_stop();
        $display("checked=%0d n_fail=%0d", checked, n_fail);
        if (n_fail == 0 && checked > 0) begin
            $display("All checks passed");
        end else begin
            $display("Checks failed");
        end
        $finish;
    endtask
    initial begin
        {rst_n, reqValid, reqRead, reqAddr, reqData} = '0;
        {n_fail, checked, cyc} = '0;
        accSample = '0;
        tempSample = 8'h00;
        repeat (20) @(posedge mclk);
        rst_n <= 1'b1;
        for (int k = 0; k < 3; k++) begin
            @(posedge mclk) accSample <= {ax[2], ax[1], ax[0]};
            xfer(1'b1, 7'h02 + 7'(2 * k), {1'b0, ax[k][9:3]}, 1'b1);
            @(posedge mclk) accSample <= ~{ax[2], ax[1], ax[0]};
            xfer(1'b1, 7'h03 + 7'(2 * k), {5'h00, ax[k][2:0]}, 1'b1);
        end
        $display("test acc done");
        for (int k = 0; k < 2; k++) begin
            @(posedge mclk) tempSample <= tv[k];
            repeat (50) @(posedge mclk);
            xfer(1'b1, 7'h08, tv[k], 1'b1);
        end
        $display("test temp done");
        for (int k = 1; k >= 0; k--) begin
            xfer(1'b0, 7'h14, 8'(k), 1'b0);
            chk({15'h0000, range10g}, 16'(k));
        end
        $display("test range done");
        xfer(1'b0, 7'h45, 8'hC3, 1'b0);
        xfer(1'b1, 7'h45, 8'h00, 1'b0);
        xfer(1'b1, 7'h30, 8'hC3, 1'b1);
        xfer(1'b1, 7'h30, 8'h00, 1'b1);
        $display("test memory done");
        report_and_stop();
    end
endmodule // accel_sensor_spi_slave_tb
